// ---- bench/board_model.sv ----
// board circuitry around the bidirectional pin and the hold pin
// assumes the bench sets the board's drive and hold levels on sys_clk
`timescale 1ns/1ps
module board_model (
   input wire logic sys_clk, // system clock
   input wire logic pin_o, // design drive value
   input wire logic pin_oe_n, // design drives when low
   input wire logic drive_en, // board drives the pin
   input wire logic drive_val, // board drive level
   input wire logic hold_level, // wanted hold pin level
   output logic pin_i, // resolved pin level
   output logic hold_pin // hold pin to the design
);
   logic float_q = 1'b0;
   // an undriven line has no pull, so it wanders every cycle
   always_ff @(posedge sys_clk) begin
      float_q <= ~float_q;
   end
   // resolve the wire from both drivers, design first
   always_comb begin
      if (pin_oe_n == 1'b0) begin
         pin_i = pin_o;
      end else if (drive_en) begin
         pin_i = drive_val;
      end else begin
         pin_i = float_q;
      end
   end
   // the board decides when to hold and when to release
   assign hold_pin = hold_level;
endmodule : board_model

// ---- bench/tb_output_ports_with_tone_select.sv ----
// self-checking bench for the output ports and tone-select block
// assumes the board model beside the design and an AXI4-Lite master here
`timescale 1ns/1ps
module tb_output_ports_with_tone_select;
   import port_pkg::*;
   localparam int TH = 128; // short tone half period keeps the run brief
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic brd_en = 1'b0, brd_val = 1'b0, hold_lvl = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe_n;
   logic pin_i, hold_pin, clk_stop;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] n_o, n_oe_n, a_o, a_oe_n, b_o, b_oe_n;
   int failures = 0, n_checks = 0, cyc = 0;

   port_block #(.TONE_HALF(TH)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .tone_port_o(n_o),
      .tone_port_oe_n(n_oe_n), .out_port_a_o(a_o), .out_port_a_oe_n(a_oe_n),
      .out_port_b_o(b_o), .out_port_b_oe_n(b_oe_n),
      .single_bidir_pin_i(pin_i), .single_bidir_pin_o(pin_o),
      .single_bidir_pin_oe_n(pin_oe_n), .hold_pin_i(hold_pin),
      .clk_stop_o(clk_stop));
   board_model board (.sys_clk(sys_clk), .pin_o(pin_o),
      .pin_oe_n(pin_oe_n), .drive_en(brd_en), .drive_val(brd_val),
      .hold_level(hold_lvl), .pin_i(pin_i), .hold_pin(hold_pin));

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   // a hung handshake ends the run here
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failures++;
         summarize();
      end
   end

   task summarize();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] act, input logic [31:0] exp);
      n_checks++;
      if (act !== exp) begin
         failures++;
         $display("[ERR] t=%0t got %h exp %h", $time, act, exp);
      end
   endtask : chk
   task chk_n(input int act, input int exp);
      n_checks++;
      if (act != exp) begin
         failures++;
         $display("[ERR] t=%0t count %h exp %h", $time, act, exp);
      end
   endtask : chk_n
   // readiness is sampled at the falling edge, so it is the value
   // that the next rising edge sees, with no race against the design
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
      bit ta, tw, tb, done;
      @(posedge sys_clk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s;
      wvalid <= 1'b1; bready <= 1'b1; done = 0;
      while (!done) begin
         @(negedge sys_clk);
         ta = awvalid && (awready === 1'b1);
         tw = wvalid && (wready === 1'b1);
         tb = (bvalid === 1'b1);
         if (tb) r = bresp;
         @(posedge sys_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0; done = 1;
         end
      end
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      bit ta, tr, done;
      @(posedge sys_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1; done = 0;
      while (!done) begin
         @(negedge sys_clk);
         ta = arvalid && (arready === 1'b1);
         tr = (rvalid === 1'b1);
         if (tr) begin
            d = rdata; r = rresp;
         end
         @(posedge sys_clk);
         if (ta) arvalid <= 1'b0;
         if (tr) begin
            rready <= 1'b0; done = 1;
         end
      end
   endtask : rd
   // skips a possibly partial first half and one whole half, then counts the next whole half
   task half_len(output int n);
      logic v;
      @(negedge sys_clk);
      v = n_o[0];
      for (int k = 0; k < 2; k++) begin
         while (n_o[0] === v) @(negedge sys_clk);
         v = n_o[0];
      end
      n = 0;
      while (n_o[0] === v) begin
         @(negedge sys_clk);
         n++;
      end
   endtask : half_len

   task t_reset();
      @(negedge sys_clk);
      chk(32'({n_oe_n, a_oe_n, b_oe_n}), 32'hfff);
      chk(32'(pin_oe_n), 32'h1);
      chk(32'(clk_stop), 32'h0);
      $display("test reset done");
   endtask : t_reset
   task t_plain();
      logic [1:0] r;
      wr(ADDR_PORT_N, 32'ha, 4'hf, r);
      @(negedge sys_clk);
      chk(32'({n_oe_n, n_o}), 32'h0a);
      chk(32'({a_oe_n, b_oe_n}), 32'hff);
      wr(ADDR_PORT_A, 32'h5, 4'hf, r);
      wr(ADDR_PORT_B, 32'h3, 4'hf, r);
      @(negedge sys_clk);
      chk(32'({a_oe_n, a_o, b_oe_n, b_o}), 32'h0503);
      $display("test plain outputs done");
   endtask : t_plain
   task t_tone();
      logic [1:0] r;
      logic v;
      int n;
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_TONE, 32'h8 | 32'(c), 4'hf, r);
         half_len(n);
         chk_n(n, TH >> c);
      end
      // the latch moves, but bit0 keeps carrying the tone
      wr(ADDR_PORT_N, 32'h7, 4'hf, r);
      @(negedge sys_clk);
      chk(32'(n_o[3:1]), 32'h3);
      v = n_o[0];
      @(negedge sys_clk);
      chk(32'(n_o[0]), 32'(!v));
      wr(ADDR_TONE, 32'h5, 4'hf, r);
      @(negedge sys_clk);
      chk(32'({n_oe_n, n_o}), 32'h07);
      $display("test tone done");
   endtask : t_tone
   task t_bidir();
      logic [1:0] r;
      logic [31:0] d;
      @(posedge sys_clk);
      brd_en <= 1'b1; brd_val <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(ADDR_BDIR_DATA, d, r);
      chk(d, 32'h1);
      brd_val <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd(ADDR_BDIR_DATA, d, r);
      chk(d, 32'h0);
      brd_en <= 1'b0; // board lets go before the design drives
      wr(ADDR_BDIR_CFG, 32'h1, 4'hf, r);
      wr(ADDR_BDIR_DATA, 32'h1, 4'hf, r);
      @(negedge sys_clk);
      chk(32'({pin_oe_n, pin_o}), 32'h1);
      wr(ADDR_BDIR_DATA, 32'h0, 4'he, r);
      rd(ADDR_BDIR_DATA, d, r);
      chk(32'({pin_o, d[0]}), 32'h3);
      $display("test bidir done");
   endtask : t_bidir
   task t_stop();
      logic [1:0] r;
      logic [31:0] d;
      int n;
      @(posedge sys_clk);
      hold_lvl <= 1'b0;
      repeat (4) @(posedge sys_clk);
      wr(ADDR_CLK_STOP, 32'h1, 4'hf, r);
      @(negedge sys_clk);
      chk(32'(clk_stop), 32'h0);
      wr(ADDR_HOLD_EN, 32'h1, 4'hf, r);
      wr(ADDR_CLK_STOP, 32'h1, 4'hf, r);
      brd_en <= 1'b1; brd_val <= 1'b1;
      @(negedge sys_clk);
      chk(32'(clk_stop), 32'h1);
      chk(32'({n_oe_n, a_oe_n, b_oe_n}), 32'hfff);
      chk(32'(pin_oe_n), 32'h1);
      repeat (4) @(posedge sys_clk);
      rd(ADDR_BDIR_DATA, d, r);
      chk(d, 32'h0);
      brd_en <= 1'b0;
      hold_lvl <= 1'b1;
      n = 0;
      while (clk_stop !== 1'b0 && n < 8) begin
         @(negedge sys_clk);
         n++;
      end
      chk(32'(clk_stop), 32'h0);
      @(negedge sys_clk);
      chk(32'({n_oe_n, pin_oe_n}), 32'h0);
      $display("test clock stop done");
   endtask : t_stop
   task t_unmapped();
      logic [1:0] r;
      logic [31:0] d;
      wr(8'h40, 32'h1, 4'hf, r);
      chk(32'(r), 32'(RESP_SLVERR));
      rd(8'h40, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      rd(ADDR_PORT_A, d, r);
      chk(32'({r, d[3:0]}), 32'h05);
      rd(ADDR_TONE, d, r);
      chk(d, 32'h5);
      // hold high, no stop, all three ports driving, tone idle
      rd(ADDR_STATUS, d, r);
      chk(d, 32'h1e);
      $display("test unmapped done");
   endtask : t_unmapped

   initial begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_plain();
      t_tone();
      t_bidir();
      t_stop();
      t_unmapped();
      summarize();
   end
endmodule : tb_output_ports_with_tone_select

// ---- pkg/port_pkg.sv ----
// constants for the output-port and tone-select block
// assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock
package port_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_PORT_N = 8'h00; // tone-shared port latch
   localparam logic [7:0] ADDR_PORT_A = 8'h04; // output-only port a
   localparam logic [7:0] ADDR_PORT_B = 8'h08; // output-only port b
   localparam logic [7:0] ADDR_TONE = 8'h0c; // tone-select word
   localparam logic [7:0] ADDR_BDIR_CFG = 8'h10; // bidir direction
   localparam logic [7:0] ADDR_BDIR_DATA = 8'h14; // bidir out/in
   localparam logic [7:0] ADDR_HOLD_EN = 8'h18; // hold-enable flag
   localparam logic [7:0] ADDR_CLK_STOP = 8'h1c; // clock-stop command
   localparam logic [7:0] ADDR_STATUS = 8'h20; // block state
   // tone-select word fields
   localparam int TONE_MODE_BIT = 3;
   localparam int TONE_CODE_W = 3;
   // reset values
   localparam logic [3:0] PORT_RST = 4'h0;
   localparam logic [2:0] TONE_CODE_RST = 3'h0;
   // tone half period for code 0, in sys_clk cycles (1 kHz at 50 MHz)
   localparam int TONE_HALF0 = 25000;
   localparam int TONE_CNT_W = 16;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // register selector
   typedef enum {
      SEL_PORT_N, SEL_PORT_A, SEL_PORT_B, SEL_TONE, SEL_BDIR_CFG,
      SEL_BDIR_DATA, SEL_HOLD_EN, SEL_CLK_STOP, SEL_STATUS, SEL_NONE
   } reg_sel_t;
endpackage : port_pkg

// ---- pkg/tone_if.sv ----
// control and result of the tone generator
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface tone_if;
   logic en; // tone mode selected
   logic [2:0] code; // frequency code
   logic wave; // square wave
   modport gen (input en, input code, output wave);
   modport ctl (output en, output code, input wave);
endinterface : tone_if

// ---- src/port_block.sv ----
// output-only ports, tone-shared port and single bidirectional pin
// assumes AXI4-Lite master on sys_clk; pins and hold pin are asynchronous
// Summary of operation
// - tone word bit 3 clear: shared pin outputs its port latch bit.
// - tone word bit 3 set: shared pin outputs the tone instead.
// - tone word bits 2..0 pick the tone frequency.
// - other three pins of the shared port are plain outputs only.
// - in tone mode a port write updates the latch, not the pin.
// - all output-only pins float while clock stop is active.
// - output-only ports float from reset until their first write.
// - bidir direction from config word; data via register out/in.
// - no bit operations on the bidir pin; a write takes effect only with wstrb bit 0 set.
// - in clock stop the bidir pin floats and its input is disabled.
// - reset makes the bidir pin an input.
// - stop needs hold enable, hold low, stop command; hold high exits.
`timescale 1ns/1ps
module port_block #(
   parameter int TONE_HALF = port_pkg::TONE_HALF0 // tone half period
) (
   input wire logic sys_clk, // system clock 50 MHz
   input wire logic sys_rst, // synchronous reset, high
   input wire logic [7:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // write strobes
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [7:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   output logic [3:0] tone_port_o, // bit0 tone_shared_pin
   output logic [3:0] tone_port_oe_n, // low drives
   output logic [3:0] out_port_a_o, // output-only port a
   output logic [3:0] out_port_a_oe_n, // low drives
   output logic [3:0] out_port_b_o, // output-only port b
   output logic [3:0] out_port_b_oe_n, // low drives
   input wire logic single_bidir_pin_i, // pin level
   output logic single_bidir_pin_o, // pin drive value
   output logic single_bidir_pin_oe_n, // low drives
   input wire logic hold_pin_i, // hold pin, asynchronous
   output logic clk_stop_o // clock stop active
);
   import port_pkg::*;

   // address decode, shared by the write and read paths
   function automatic reg_sel_t decode(input logic [7:0] a);
      case (a)
         ADDR_PORT_N: decode = SEL_PORT_N;
         ADDR_PORT_A: decode = SEL_PORT_A;
         ADDR_PORT_B: decode = SEL_PORT_B;
         ADDR_TONE: decode = SEL_TONE;
         ADDR_BDIR_CFG: decode = SEL_BDIR_CFG;
         ADDR_BDIR_DATA: decode = SEL_BDIR_DATA;
         ADDR_HOLD_EN: decode = SEL_HOLD_EN;
         ADDR_CLK_STOP: decode = SEL_CLK_STOP;
         ADDR_STATUS: decode = SEL_STATUS;
         default: decode = SEL_NONE;
      endcase
   endfunction : decode

   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic aw_have_q, w_have_q;
   logic [7:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic aw_hs, w_hs, ar_hs, wr_go;
   reg_sel_t wsel;
   logic [3:0] n_latch_q, a_latch_q, b_latch_q;
   logic n_drive_q, a_drive_q, b_drive_q;
   logic tone_mode_q;
   logic [2:0] tone_code_q;
   logic bdir_out_q, bdir_latch_q;
   logic hold_en_q, clk_stop_q;
   logic hold_m_q, hold_s_q, bpin_m_q, bpin_s_q;
   logic [3:0] tone_o_q, tone_oe_n_q;
   logic [3:0] a_o_q, a_oe_n_q, b_o_q, b_oe_n_q;
   logic bpin_o_q, bpin_oe_n_q;
   logic bdir_in;
   tone_if tone ();

   assign aw_hs = awvalid & awready_q;
   assign w_hs = wvalid & wready_q;
   assign ar_hs = arvalid & arready_q;
   assign wr_go = aw_have_q & w_have_q & ~bvalid_q;
   assign wsel = decode(waddr_q);

   // write address channel; one write in flight at a time
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b0;
         waddr_q <= 8'h00;
      end else if (aw_hs) begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b1;
         waddr_q <= awaddr;
      end else if (wr_go) begin
         aw_have_q <= 1'b0;
      end else if (!aw_have_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   // write data channel, taken independently of the address
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wready_q <= 1'b0;
         w_have_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (w_hs) begin
         wready_q <= 1'b0;
         w_have_q <= 1'b1;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else if (wr_go) begin
         w_have_q <= 1'b0;
      end else if (!w_have_q && !bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   // write response once both halves are in
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_q && bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // output latches; a write is the port's output instruction
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         n_latch_q <= PORT_RST;
         a_latch_q <= PORT_RST;
         b_latch_q <= PORT_RST;
         n_drive_q <= 1'b0;
         a_drive_q <= 1'b0;
         b_drive_q <= 1'b0;
      end else if (wr_go && wstrb_q[0]) begin
         case (wsel)
            SEL_PORT_N: begin
               n_latch_q <= wdata_q[3:0];
               n_drive_q <= 1'b1;
            end
            SEL_PORT_A: begin
               a_latch_q <= wdata_q[3:0];
               a_drive_q <= 1'b1;
            end
            SEL_PORT_B: begin
               b_latch_q <= wdata_q[3:0];
               b_drive_q <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // tone select, bidir and hold controls
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tone_mode_q <= 1'b0;
         tone_code_q <= TONE_CODE_RST;
         bdir_out_q <= 1'b0;
         bdir_latch_q <= 1'b0;
         hold_en_q <= 1'b0;
      end else if (wr_go && wstrb_q[0]) begin
         case (wsel)
            SEL_TONE: begin
               tone_mode_q <= wdata_q[TONE_MODE_BIT];
               tone_code_q <= wdata_q[TONE_CODE_W-1:0];
            end
            SEL_BDIR_CFG: bdir_out_q <= wdata_q[0];
            // only a write with wstrb bit 0 set reaches the bidir latch
            SEL_BDIR_DATA: bdir_latch_q <= wdata_q[0];
            SEL_HOLD_EN: hold_en_q <= wdata_q[0];
            default: begin
            end
         endcase
      end
   end

   // pin synchronisers; the first stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         hold_m_q <= 1'b1;
         hold_s_q <= 1'b1;
         bpin_m_q <= 1'b0;
         bpin_s_q <= 1'b0;
      end else begin
         hold_m_q <= hold_pin_i;
         hold_s_q <= hold_m_q;
         bpin_m_q <= single_bidir_pin_i;
         bpin_s_q <= bpin_m_q;
      end
   end

   // clock stop; a stop command with hold high is simply ignored
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         clk_stop_q <= 1'b0;
      end else if (clk_stop_q && hold_s_q) begin
         clk_stop_q <= 1'b0;
      end else if (wr_go && wsel == SEL_CLK_STOP && hold_en_q &&
         !hold_s_q) begin
         clk_stop_q <= 1'b1;
      end
   end

   assign tone.en = tone_mode_q;
   assign tone.code = tone_code_q;

   tone_gen #(.HALF0(TONE_HALF)) u_tone (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .t(tone.gen)
   );

   // pin registers; every pin comes straight from a flip-flop
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tone_o_q <= 4'h0;
         tone_oe_n_q <= 4'hf;
         a_o_q <= 4'h0;
         a_oe_n_q <= 4'hf;
         b_o_q <= 4'h0;
         b_oe_n_q <= 4'hf;
      end else begin
         tone_o_q[0] <= tone_mode_q ? tone.wave : n_latch_q[0];
         tone_o_q[3:1] <= n_latch_q[3:1];
         tone_oe_n_q <= {4{~n_drive_q | clk_stop_q}};
         a_o_q <= a_latch_q;
         a_oe_n_q <= {4{~a_drive_q | clk_stop_q}};
         b_o_q <= b_latch_q;
         b_oe_n_q <= {4{~b_drive_q | clk_stop_q}};
      end
   end

   // bidir pin drives only when configured out and running
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bpin_o_q <= 1'b0;
         bpin_oe_n_q <= 1'b1;
      end else begin
         bpin_o_q <= bdir_latch_q;
         bpin_oe_n_q <= ~bdir_out_q | clk_stop_q;
      end
   end

   // input path closed in clock stop; output mode reads its latch
   assign bdir_in = clk_stop_q ? 1'b0 :
      (bdir_out_q ? bdir_latch_q : bpin_s_q);

   // read channel, answered at the same edge that takes the address
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (ar_hs) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         case (decode(araddr))
            SEL_PORT_N: rdata_q[3:0] <= n_latch_q;
            SEL_PORT_A: rdata_q[3:0] <= a_latch_q;
            SEL_PORT_B: rdata_q[3:0] <= b_latch_q;
            SEL_TONE: rdata_q[3:0] <= {tone_mode_q, tone_code_q};
            SEL_BDIR_CFG: rdata_q[0] <= bdir_out_q;
            SEL_BDIR_DATA: rdata_q[0] <= bdir_in;
            SEL_HOLD_EN: rdata_q[0] <= hold_en_q;
            SEL_CLK_STOP: rdata_q[0] <= clk_stop_q;
            SEL_STATUS: rdata_q[5:0] <= {tone.wave, b_drive_q,
               a_drive_q, n_drive_q, hold_s_q, clk_stop_q};
            default: rresp_q <= RESP_SLVERR;
         endcase
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign tone_port_o = tone_o_q;
   assign tone_port_oe_n = tone_oe_n_q;
   assign out_port_a_o = a_o_q;
   assign out_port_a_oe_n = a_oe_n_q;
   assign out_port_b_o = b_o_q;
   assign out_port_b_oe_n = b_oe_n_q;
   assign single_bidir_pin_o = bpin_o_q;
   assign single_bidir_pin_oe_n = bpin_oe_n_q;
   assign clk_stop_o = clk_stop_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   AST_GPIO_MODE: assert property (!tone_mode_q |=>
      tone_port_o[0] == $past(n_latch_q[0]))
      else $error("shared pin not following latch");
   AST_TONE_MODE: assert property (tone_mode_q |=>
      tone_port_o[0] == $past(tone.wave))
      else $error("shared pin not following tone");
   AST_TONE_CODE: assert property ((wr_go && wstrb_q[0] &&
      wsel == SEL_TONE) |=> tone_code_q == $past(wdata_q[2:0]))
      else $error("tone code not taken");
   AST_PLAIN_PINS: assert property (1'b1 |=>
      tone_port_o[3:1] == $past(n_latch_q[3:1]))
      else $error("plain pins not from latch");
   AST_LATCH_IN_TONE: assert property ((wr_go && wstrb_q[0] &&
      wsel == SEL_PORT_N && tone_mode_q) |=>
      n_latch_q == $past(wdata_q[3:0]) ##1
      tone_port_o[0] == $past(tone.wave))
      else $error("latch write in tone mode misbehaved");
   AST_STOP_FLOAT: assert property (clk_stop_q |=>
      (&tone_port_oe_n) && (&out_port_a_oe_n) && (&out_port_b_oe_n))
      else $error("output pin driven in clock stop");
   AST_NO_DRIVE: assert property (!n_drive_q |=> &tone_port_oe_n)
      else $error("port driven before first write");
   AST_BDIR_OUT: assert property ((bdir_out_q && !clk_stop_q) |=>
      !single_bidir_pin_oe_n &&
      single_bidir_pin_o == $past(bdir_latch_q))
      else $error("bidir pin not driving latch");
   // input path is judged in the stop cycle itself, since the exit edge
   // reopens it at once while the pin register lags by one edge
   AST_BDIR_STOP: assert property (clk_stop_q |->
      bdir_in == 1'b0 ##1 single_bidir_pin_oe_n)
      else $error("bidir pin active in clock stop");
   AST_BDIR_RST: assert property ($past(sys_rst) |->
      !bdir_out_q && single_bidir_pin_oe_n)
      else $error("bidir pin not input after reset");
   AST_STOP_ENTRY: assert property ($rose(clk_stop_q) |->
      $past(hold_en_q) && !$past(hold_s_q) &&
      $past(wsel) == SEL_CLK_STOP)
      else $error("clock stop entered without its conditions");
   AST_STOP_EXIT: assert property ((clk_stop_q && hold_s_q) |=>
      !clk_stop_q)
      else $error("clock stop not left with hold high");

   COV_TONE: cover property (tone_mode_q ##1 $changed(tone_port_o[0]));
   COV_STOP: cover property ($rose(clk_stop_q) ##[1:20] $fell(clk_stop_q));
   COV_BDIR: cover property (ar_hs && decode(araddr) == SEL_BDIR_DATA);
endmodule : port_block

// ---- src/tone_gen.sv ----
// square-wave tone from a sys_clk divider, eight distinct rates
// assumes code is steady for the length of a tone
`timescale 1ns/1ps
module tone_gen #(
   parameter int HALF0 = port_pkg::TONE_HALF0 // half period, code 0
) (
   input wire logic sys_clk, // system clock
   input wire logic sys_rst, // synchronous reset, high
   tone_if.gen t // tone control
);
   import port_pkg::*;
   logic [TONE_CNT_W-1:0] cnt_q;
   logic [TONE_CNT_W-1:0] limit;
   logic tick;
   logic wave_q;

   // each code halves the period, so all eight rates differ
   assign limit = TONE_CNT_W'(HALF0) >> t.code;
   assign tick = (cnt_q >= limit - 1'b1);

   // divider producing a one-cycle enable
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !t.en || tick) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // wave flips on each enable pulse
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !t.en) begin
         wave_q <= 1'b0;
      end else if (tick) begin
         wave_q <= ~wave_q;
      end
   end

   assign t.wave = wave_q;

   AST_TONE_HALF: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (t.en && $past(t.en) && $changed(wave_q)) |->
      $past(cnt_q) >= $past(limit) - 1'b1)
      else $error("tone toggled before its half period");
endmodule : tone_gen
